//--- core/wdt_soft_reset.sv
`timescale 1ns/10ps
// Function
// [R1] The watchdog is a 15-bit counter counting down while running.
// [R2] An underflow raises a watchdog interrupt request to the core.
// [R3] The watchdog request is nonmaskable; no flag or level blocks it.
// [R4] After reset the watchdog stays stopped until a start write.
// [R5] Each start write reloads 7FFFH; the written data are ignored.
// [R6] Software must write the start register before each underflow.
// [R7] Writing 1 to bit 3 of mode register 0 performs a software reset.
// [R8] The reset sequence starts at once; no instruction runs after it.
// [R9] A software reset leaves the internal RAM contents unchanged.
// [R10] Accepting the watchdog interrupt fetches its own vector entry.
// [R11] Acceptance sets priority level 7; only a true reset clears it.
// [R12] The counter steps once per prescaled tick; reset stops it.
module wdt_soft_reset
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               ce,
    // Register port
    input  wire logic [ADDR_W-1:0]  addr,
    input  wire logic [DATA_W-1:0]  wr_data,
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    output logic [DATA_W-1:0]       rd_data_q,
    // Processor side
    input  wire logic               int_ack,
    output logic                    nmi_req_q,
    output logic [19:0]             vector_addr_q,
    output logic                    vector_valid_q,
    output logic [PRIO_W-1:0]       priority_level_q,
    output logic                    core_reset_q,
    output logic                    ram_keep_q,
    // Interrupt
    output logic                    irq_q
);

    // Register decode
    logic                   wr_start;
    logic                   wr_mode0;
    logic                   wr_status;
    logic                   wr_mask;
    logic                   wr_prescale;
    logic                   soft_rst_req;
    logic                   int_take;

    // Watchdog state
    logic [COUNT_W-1:0]     count_q;
    logic                   running_q;
    logic                   underflow_q;
    logic                   tick_q;

    // Control and event registers
    logic [7:0]             mode0_q;
    logic [PRESCALE_W-1:0]  prescale_q;
    logic [EVT_W-1:0]       mask_q;
    logic [EVT_W-1:0]       status_q;
    logic [EVT_W-1:0]       event_set;

    // Reset sequence
    seq_state_t             seq_state_q;
    seq_state_t             seq_state_d;
    logic [4:0]             seq_cnt_q;
    logic                   seq_active;
    logic                   seq_done;
    logic                   counter_stop;

    // Register decode; the slave never inserts wait states
    assign wr_start     = wr_en && (addr == OFS_START);
    assign wr_mode0     = wr_en && (addr == OFS_MODE0);
    assign wr_status    = wr_en && (addr == OFS_INT_STATUS);
    assign wr_mask      = wr_en && (addr == OFS_INT_MASK);
    assign wr_prescale  = wr_en && (addr == OFS_PRESCALE);
    assign soft_rst_req = wr_mode0 && wr_data[MODE0_SOFT_RST_BIT]; // [R7]
    assign int_take     = int_ack && nmi_req_q;

    // Reset sequence status
    assign seq_active   = (seq_state_q == SEQ_RESET);
    assign seq_done     = seq_active && (seq_cnt_q == SEQ_LAST);
    // The setting write itself already halts the counter
    assign counter_stop = seq_active || soft_rst_req;              // [R8]

    // Prescaled tick
    wdt_prescaler u_prescaler (
        .core_clk (core_clk),
        .reset    (reset),
        .ce       (ce),
        .run      (running_q),
        .divisor  (prescale_q),
        .tick_q   (tick_q)
    );

    // 15-bit down counter, reloaded by any start write
    wdt_counter u_counter (
        .core_clk    (core_clk),
        .reset       (reset),
        .ce          (ce),
        .stop        (counter_stop),
        .load        (wr_start),
        .tick        (tick_q),
        .count_q     (count_q),
        .running_q   (running_q),
        .underflow_q (underflow_q)
    );

    // Prescaler divisor
    always_ff @(posedge core_clk) begin
        if (reset) begin
            prescale_q <= PRESCALE_RESET;
        end else if (ce) begin
            if (wr_prescale) begin
                prescale_q <= wr_data[PRESCALE_W-1:0];
            end
        end
    end

    // Interrupt mask; it gates only irq, never the watchdog request
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mask_q <= INT_MASK_RESET;
        end else if (ce) begin
            if (wr_mask) begin
                mask_q <= wr_data[EVT_W-1:0];
            end
        end
    end

    // Mode register 0
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mode0_q <= MODE0_RESET;
        end else if (ce) begin
            if (wr_mode0) begin
                mode0_q                     <= wr_data[7:0];
                // Reads back as 0: the bit only launches the sequence
                mode0_q[MODE0_SOFT_RST_BIT] <= 1'b0;
            end
        end
    end

    // Event strobes, one per status bit
    always_comb begin
        event_set                    = '0;
        event_set[EVT_UNDERFLOW_BIT] = underflow_q;
        event_set[EVT_SOFT_RST_BIT]  = soft_rst_req;
    end

    // Sticky status bits, cleared by writing a one
    genvar gi;
    generate
        for (gi = 0; gi < EVT_W; gi = gi + 1) begin : g_status
            always_ff @(posedge core_clk) begin
                if (reset) begin
                    status_q[gi] <= 1'b0;
                end else if (ce) begin
                    if (event_set[gi]) begin
                        // A new event beats a clear in the same cycle
                        status_q[gi] <= 1'b1;
                    end else if (wr_status && wr_data[gi]) begin
                        status_q[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Level interrupt of the status block
    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq_q <= 1'b0;
        end else if (ce) begin
            irq_q <= |(status_q & mask_q);
        end
    end

    // Watchdog request: no mask, enable or level takes part
    always_ff @(posedge core_clk) begin
        if (reset) begin
            nmi_req_q <= 1'b0;
        end else if (ce) begin
            if (underflow_q) begin
                nmi_req_q <= 1'b1;                                 // [R2] [R3]
            end else if (int_take) begin
                nmi_req_q <= 1'b0;
            end
        end
    end

    // Priority level; the soft reset sequence leaves it alone
    always_ff @(posedge core_clk) begin
        if (reset) begin
            priority_level_q <= PRIO_RESET;                        // [R11]
        end else if (ce) begin
            if (int_take) begin
                priority_level_q <= PRIO_WDT;                      // [R11]
            end
        end
    end

    // Vector entry handed over with the acceptance
    always_ff @(posedge core_clk) begin
        if (reset) begin
            vector_addr_q  <= '0;
            vector_valid_q <= 1'b0;
        end else if (ce) begin
            vector_valid_q <= int_take;                            // [R10]
            if (int_take) begin
                vector_addr_q <= WDT_VECTOR_ADDR;                  // [R10]
            end
        end
    end

    // Reset sequence state machine
    always_comb begin
        seq_state_d = seq_state_q;
        case (seq_state_q)
            SEQ_IDLE: begin
                if (soft_rst_req) begin
                    seq_state_d = SEQ_RESET;                       // [R8]
                end
            end
            SEQ_RESET: begin
                if (seq_done) begin
                    seq_state_d = SEQ_IDLE;
                end
            end
            default: begin
                seq_state_d = SEQ_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            seq_state_q <= SEQ_IDLE;
        end else if (ce) begin
            seq_state_q <= seq_state_d;
        end
    end

    // Length of the reset sequence
    always_ff @(posedge core_clk) begin
        if (reset) begin
            seq_cnt_q <= 5'h00;
        end else if (ce) begin
            if (seq_active && !seq_done) begin
                seq_cnt_q <= seq_cnt_q + 5'h01;
            end else begin
                seq_cnt_q <= 5'h00;
            end
        end
    end

    // Core reset rises with the setting write, so nothing runs after it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            core_reset_q <= 1'b0;
        end else if (ce) begin
            if (soft_rst_req) begin
                core_reset_q <= 1'b1;                              // [R8]
            end else if (seq_done) begin
                core_reset_q <= 1'b0;
            end
        end
    end

    // This sequence never clears memory; a true reset is not ours
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ram_keep_q <= 1'b0;
        end else if (ce) begin
            if (soft_rst_req) begin
                ram_keep_q <= 1'b1;                                // [R9]
            end else if (seq_done) begin
                ram_keep_q <= 1'b0;
            end
        end
    end

    // Read data stand for exactly one cycle after the read strobe
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rd_data_q <= '0;
        end else if (ce) begin
            if (rd_en) begin
                case (addr)
                    OFS_COUNT: begin
                        rd_data_q <= {running_q, count_q};         // [R4]
                    end
                    OFS_MODE0: begin
                        rd_data_q <= {8'h00, mode0_q};
                    end
                    OFS_INT_STATUS: begin
                        rd_data_q <= {14'h0000, status_q};
                    end
                    OFS_INT_MASK: begin
                        rd_data_q <= {14'h0000, mask_q};
                    end
                    OFS_PRESCALE: begin
                        rd_data_q <= {8'h00, prescale_q};
                    end
                    OFS_PRIORITY: begin
                        rd_data_q <= {13'h0000, priority_level_q};
                    end
                    default: begin
                        rd_data_q <= '0;
                    end
                endcase
            end else begin
                rd_data_q <= '0;
            end
        end
    end

endmodule // wdt_soft_reset

//--- inc/wdt_pkg.sv
package wdt_pkg;

    // Counter geometry and fixed reload value
    localparam int          COUNT_W        = 15;
    localparam logic [14:0] RELOAD_VALUE   = 15'h7FFF;

    // Register port geometry
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 16;

    // Register offsets
    localparam logic [3:0]  OFS_START      = 4'h0;
    localparam logic [3:0]  OFS_COUNT      = 4'h1;
    localparam logic [3:0]  OFS_MODE0      = 4'h2;
    localparam logic [3:0]  OFS_INT_STATUS = 4'h3;
    localparam logic [3:0]  OFS_INT_MASK   = 4'h4;
    localparam logic [3:0]  OFS_PRESCALE   = 4'h5;
    localparam logic [3:0]  OFS_PRIORITY   = 4'h6;

    // Field positions
    localparam int          MODE0_SOFT_RST_BIT = 3;
    localparam int          COUNT_RUN_BIT      = 15;
    localparam int          EVT_UNDERFLOW_BIT  = 0;
    localparam int          EVT_SOFT_RST_BIT   = 1;
    localparam int          EVT_W              = 2;
    localparam int          PRIO_W             = 3;
    localparam int          PRESCALE_W         = 8;

    // Reset values
    localparam logic [7:0]  MODE0_RESET    = 8'h00;
    localparam logic [1:0]  INT_MASK_RESET = 2'h0;
    localparam logic [7:0]  PRESCALE_RESET = 8'hFF;
    localparam logic [2:0]  PRIO_RESET     = 3'h0;
    localparam logic [2:0]  PRIO_WDT       = 3'h7;

    // Vector table entry of the watchdog interrupt (arbitrary value)
    localparam logic [19:0] WDT_VECTOR_ADDR = 20'hFFFF0;

    // Reset sequence timing
    localparam int          SEQ_TIME_NS    = 128;
    localparam int          CLK_PERIOD_NS  = 8;
    localparam int          SEQ_CYCLES     = SEQ_TIME_NS / CLK_PERIOD_NS;
    localparam logic [4:0]  SEQ_LAST       = 5'(SEQ_CYCLES - 1);

    typedef enum logic [0:0] {
        SEQ_IDLE  = 1'b0,
        SEQ_RESET = 1'b1
    } seq_state_t;

endpackage

//--- core/wdt_prescaler.sv
`timescale 1ns/10ps
module wdt_prescaler
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  reset,
    input  wire logic                  ce,
    // Control
    input  wire logic                  run,
    input  wire logic [PRESCALE_W-1:0] divisor,
    // Tick out
    output logic                       tick_q
);

    logic [PRESCALE_W-1:0] div_cnt_q;

    // One tick every divisor+1 cycles while the watchdog runs
    always_ff @(posedge core_clk) begin
        if (reset) begin
            div_cnt_q <= '0;
            tick_q    <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                div_cnt_q <= '0;
                tick_q    <= 1'b0;
            end else if (div_cnt_q >= divisor) begin
                div_cnt_q <= '0;
                tick_q    <= 1'b1;
            end else begin
                div_cnt_q <= div_cnt_q + 8'h01;
                tick_q    <= 1'b0;
            end
        end
    end

endmodule // wdt_prescaler

//--- core/wdt_counter.sv
`timescale 1ns/10ps
module wdt_counter
    import wdt_pkg::*;
(
    // Clock and reset
    input  wire logic               core_clk,
    input  wire logic               reset,
    input  wire logic               ce,
    // Control
    input  wire logic               stop,
    input  wire logic               load,
    input  wire logic               tick,
    // State
    output logic [COUNT_W-1:0]      count_q,
    output logic                    running_q,
    output logic                    underflow_q
);

    // Stop has priority: it comes from the reset sequence
    always_ff @(posedge core_clk) begin
        if (reset) begin
            running_q <= 1'b0;                         // [R4] [R12]
        end else if (ce) begin
            if (stop) begin
                running_q <= 1'b0;
            end else if (load) begin
                running_q <= 1'b1;                     // [R4]
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            count_q     <= RELOAD_VALUE;
            underflow_q <= 1'b0;
        end else if (ce) begin
            underflow_q <= 1'b0;
            if (stop) begin
                count_q <= RELOAD_VALUE;
            end else if (load) begin
                count_q <= RELOAD_VALUE;               // [R5]
            end else if (running_q && tick) begin
                if (count_q == '0) begin
                    // Keeps counting from the top after an underflow
                    count_q     <= RELOAD_VALUE;
                    underflow_q <= 1'b1;               // [R2]
                end else begin
                    count_q <= count_q - 15'h0001;     // [R1] [R12]
                end
            end
        end
    end

endmodule // wdt_counter

//--- verif/wdt_checker.sv
`timescale 1ns/10ps
module wdt_checker import wdt_pkg::*; (
    input wire logic core_clk, reset, wr_en, rd_en, int_ack, nmi_req_q,
    input wire logic vector_valid_q, core_reset_q, ram_keep_q,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data, rd_data_q,
    input wire logic [19:0] vector_addr_q,
    input wire logic [PRIO_W-1:0] priority_level_q);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    logic started_q;
    always_ff @(posedge core_clk)
        started_q <= !reset && (started_q || (wr_en && addr == OFS_START));
    a_p_vec: assert property (vector_valid_q |->
        vector_addr_q == WDT_VECTOR_ADDR) else $error("vector");
    a_p_take: assert property (int_ack && nmi_req_q |->
        ##[1:3] priority_level_q == PRIO_WDT) else $error("take");
    a_p_hold: assert property (priority_level_q == PRIO_WDT
        |=> priority_level_q == PRIO_WDT) else $error("level");
    a_p_srst: assert property (wr_en && addr == OFS_MODE0 &&
        wr_data[MODE0_SOFT_RST_BIT] |-> ##[1:2] core_reset_q)
        else $error("soft reset");
    a_p_ram: assert property (core_reset_q |-> ram_keep_q)
        else $error("ram");
    a_p_idle: assert property (rd_en && addr == OFS_COUNT && !started_q
        |=> !rd_data_q[COUNT_RUN_BIT]) else $error("idle");
    a_p_load: assert property (wr_en && addr == OFS_START ##[1:2]
        rd_en && addr == OFS_COUNT |=> rd_data_q >= 16'hFFFE)
        else $error("load");
    a_p_uf: assert property ($rose(nmi_req_q) |-> started_q)
        else $error("underflow");
endmodule // wdt_checker
bind wdt_soft_reset wdt_checker chk (.core_clk, .reset, .wr_en, .rd_en,
    .int_ack, .nmi_req_q, .vector_valid_q, .core_reset_q, .ram_keep_q,
    .addr, .wr_data, .rd_data_q, .vector_addr_q, .priority_level_q);

//--- verif/cpu_model.sv
`timescale 1ns/10ps
module cpu_model (
    input  wire logic core_clk,
    input  wire logic nmi_req_q,
    output logic      int_ack = 1'b0);
    // No enable or level of ours can hold the request off
    always @(posedge core_clk) int_ack <= nmi_req_q && !int_ack;
endmodule // cpu_model

//--- verif/tb.sv
`timescale 1ns/10ps
module tb import wdt_pkg::*;;
    logic core_clk = 0, reset = 1, wr_en = 0, rd_en = 0, rd_seen = 0;
    logic [3:0] addr = '0;
    logic [15:0] wr_data = '0, rd_data_q;
    logic int_ack, nmi_req_q, vector_valid_q, core_reset_q, ram_keep_q, irq_q;
    logic [19:0] vector_addr_q;
    logic [2:0] priority_level_q;
    logic [31:0] exp_q[$];
    logic [31:0] rnd = 32'h4A;
    int failures = 0, checks = 0, n;
    always #4 core_clk = !core_clk;
    wdt_soft_reset uut (.core_clk, .reset, .ce(1'b1), .addr, .wr_data,
        .wr_en, .rd_en, .rd_data_q, .int_ack, .nmi_req_q, .vector_addr_q,
        .vector_valid_q, .priority_level_q, .core_reset_q, .ram_keep_q,
        .irq_q);
    cpu_model cpu (.core_clk, .nmi_req_q, .int_ack);
    task check(string what, logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task summarize;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task bus(logic w, logic [3:0] a, logic [15:0] d, m);
        if (!w) exp_q.push_back({m, d});
        addr <= a;
        wr_data <= d;
        wr_en <= w;
        rd_en <= !w;
        @(posedge core_clk) {wr_en, rd_en} <= 2'h0;
        @(posedge core_clk);
    endtask
    task automatic wait_flag(ref logic f, input int lim);
        for (n = 0; n < lim && f !== 1'b1; n++) @(posedge core_clk);
        if (n == lim) begin
            failures++;
            summarize();
        end
    endtask
    always @(posedge core_clk) begin
        if (rd_seen) check("rd_data", rd_data_q & exp_q[0][31:16],
            exp_q[0][15:0]);
        if (rd_seen) void'(exp_q.pop_front());
        rd_seen <= rd_en;
    end
    initial begin
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        @(posedge core_clk);
        bus(0, OFS_COUNT, 16'h0000, 16'h8000);
        bus(0, 4'hF, 16'h0000, 16'hFFFF);
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        bus(1, OFS_START, rnd[15:0], 0);
        bus(0, OFS_COUNT, 16'hFFFE, 16'hFFFE);
        bus(1, OFS_PRESCALE, 16'h0001, 0);
        $display("start test done");
        wait_flag(nmi_req_q, 70000);
        bus(0, OFS_INT_STATUS, 16'h0001, 16'h0001);
        bus(1, OFS_INT_MASK, 16'h0003, 0);
        @(posedge core_clk) check("irq", irq_q, 1);
        bus(1, OFS_INT_STATUS, 16'h0003, 0);
        @(posedge core_clk) check("irq", irq_q, 0);
        bus(0, OFS_PRIORITY, 16'h0007, 16'h0007);
        $display("underflow test done");
        bus(1, OFS_MODE0, 16'h0008, 0);
        wait_flag(core_reset_q, 8);
        check("ram_keep", ram_keep_q, 1);
        bus(0, OFS_PRIORITY, 16'h0007, 16'h0007);
        $display("soft reset test done");
        summarize();
    end
endmodule // tb
